//--- src/ars_pkg.sv
package ars_pkg;
  // system clock and tick prescale
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_MS = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // timing in seconds
  localparam int unsigned DLY_STEP_S = 10;
  localparam int unsigned DLY_MAX_SEL = 6;
  localparam int unsigned MAN_DLY_MAX_S = 30;
  localparam int unsigned DET_OFF_S = 2;
  localparam int unsigned ACT_DEF_S = 5;
  localparam int unsigned ABORT_HOLD_TICKS = 1;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIME = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_BELL = 8'h18;
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_XZONE_BIT = 2;
  localparam int CTRL_MDLY_BIT = 3;
  localparam int CTRL_DSEL_LSB = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] TIME_RST = 32'h0000_0005;
  localparam logic [31:0] BELL_RST = 32'h0000_0201;
  // irq event bits
  localparam int EV_ALARM = 0;
  localparam int EV_RELEASE = 1;
  localparam int EV_DONE = 2;
  localparam int EV_RESET = 3;
  localparam int EV_W = 4;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ARS_MODE_CTRL_ONLY,
    ARS_MODE_BACKUP,
    ARS_MODE_EMB_ONLY,
    ARS_MODE_RSVD
  } ars_mode_t;
endpackage : ars_pkg

//--- src/ars_cfg_if.sv
`timescale 1ns/10ps
interface ars_cfg_if;
  logic [1:0] mode;
  logic xzone;
  logic man_delayed;
  logic [2:0] dly_sel;
  logic [7:0] act_s;
  logic [7:0] bell_one;
  logic [7:0] bell_two;
  logic soft_reset;
  logic [7:0] status;
  logic [ars_pkg::EV_W-1:0] events;
  logic irq;
  modport regs (output mode, xzone, man_delayed, dly_sel, act_s, bell_one, bell_two,
    soft_reset, irq, input status, events);
  modport core (input mode, xzone, man_delayed, dly_sel, act_s, bell_one, bell_two,
    soft_reset, irq, output status, events);
endinterface : ars_cfg_if

//--- src/ars_tick.sv
`timescale 1ns/10ps
module ars_tick #(
  parameter int unsigned DIV = ars_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // tick
  output logic o_tick
);
  import ars_pkg::*;
  logic [31:0] cnt_r;
  wire logic wrap = (cnt_r == 32'(DIV - 1));
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) cnt_r <= 32'h0;
    else cnt_r <= wrap ? 32'h0 : cnt_r + 32'h1;
  end
  assign o_tick = wrap;
endmodule : ars_tick

//--- src/ars_regs.sv
`timescale 1ns/10ps
module ars_regs (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // axi4-lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // core side
  ars_cfg_if.regs cfg
);
  import ars_pkg::*;
  logic aw_r, w_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r, ctrl_r, time_r, bell_r, rdata_r;
  logic [EV_W-1:0] irq_r, mask_r;
  logic bvalid_r, rvalid_r, bad_w_r, bad_r_r, srst_r;

  wire logic do_w = aw_r && w_r && !bvalid_r;
  wire logic wr_ctrl = do_w && awa_r == OFS_CTRL;
  wire logic wr_time = do_w && awa_r == OFS_TIME;
  wire logic wr_irq = do_w && awa_r == OFS_IRQ;
  wire logic wr_mask = do_w && awa_r == OFS_MASK;
  wire logic wr_cmd = do_w && awa_r == OFS_CMD;
  wire logic wr_bell = do_w && awa_r == OFS_BELL;
  wire logic wr_ok = wr_ctrl | wr_time | wr_irq | wr_mask | wr_cmd | wr_bell | awa_r == OFS_STAT;
  wire logic rd_go = i_arvalid && !rvalid_r;
  wire logic [31:0] rd_mux =
    i_araddr == OFS_CTRL ? ctrl_r :
    i_araddr == OFS_TIME ? time_r :
    i_araddr == OFS_STAT ? {24'h0, cfg.status} :
    i_araddr == OFS_IRQ ? {28'h0, irq_r} :
    i_araddr == OFS_MASK ? {28'h0, mask_r} :
    i_araddr == OFS_BELL ? bell_r : 32'h0;
  wire logic rd_ok = i_araddr inside {OFS_CTRL, OFS_TIME, OFS_STAT, OFS_IRQ, OFS_MASK,
    OFS_CMD, OFS_BELL};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] st);
    for (int i = 0; i < 4; i++) if (st[i]) old[i*8 +: 8] = nw[i*8 +: 8];
    return old;
  endfunction : merge

  assign o_awready = !aw_r;
  assign o_wready = !w_r;
  assign o_arready = !rvalid_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bad_w_r ? AXI_SLVERR : AXI_OKAY;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = bad_r_r ? AXI_SLVERR : AXI_OKAY;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= 8'h0;
      wd_r <= 32'h0;
      bvalid_r <= 1'b0;
      bad_w_r <= 1'b0;
    end else begin
      if (i_awvalid && !aw_r) begin
        aw_r <= 1'b1;
        awa_r <= i_awaddr;
      end
      if (i_wvalid && !w_r) begin
        w_r <= 1'b1;
        wd_r <= merge(32'h0, i_wdata, i_wstrb);
      end
      if (do_w) begin
        bvalid_r <= 1'b1;
        bad_w_r <= !wr_ok;
        aw_r <= 1'b0;
        w_r <= 1'b0;
      end else if (bvalid_r && i_bready) bvalid_r <= 1'b0;
    end
  end

  // strobes captured once with the data so write order of aw/w does not matter
  logic [3:0] ws_r;
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) ws_r <= 4'h0;
    else if (i_wvalid && !w_r) ws_r <= i_wstrb;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      ctrl_r <= CTRL_RST;
      time_r <= TIME_RST;
      bell_r <= BELL_RST;
      mask_r <= '0;
      irq_r <= '0;
      srst_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= merge(ctrl_r, wd_r, ws_r);
      if (wr_time) time_r <= merge(time_r, wd_r, ws_r);
      if (wr_bell) bell_r <= merge(bell_r, wd_r, ws_r);
      if (wr_mask) mask_r <= wd_r[EV_W-1:0];
      // new events win over a write-one clear
      irq_r <= (irq_r & ~(wr_irq ? wd_r[EV_W-1:0] : '0)) | cfg.events;
      srst_r <= wr_cmd && wd_r[0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      bad_r_r <= 1'b0;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      bad_r_r <= !rd_ok;
    end else if (rvalid_r && i_rready) rvalid_r <= 1'b0;
  end

  assign cfg.mode = ctrl_r[CTRL_MODE_LSB +: 2];
  assign cfg.xzone = ctrl_r[CTRL_XZONE_BIT];
  assign cfg.man_delayed = ctrl_r[CTRL_MDLY_BIT];
  assign cfg.dly_sel = ctrl_r[CTRL_DSEL_LSB +: 3];
  assign cfg.act_s = time_r[7:0];
  assign cfg.bell_one = bell_r[7:0];
  assign cfg.bell_two = bell_r[15:8];
  assign cfg.soft_reset = srst_r;
  assign cfg.irq = |(irq_r & mask_r);
endmodule : ars_regs

//--- src/ars_seq.sv
`timescale 1ns/10ps
// Notes on behaviour
// - cross-zoned manual alarm uses two-zone bell pattern
// - manual alarm starts delay, then releases
// - reset only after release timer, manual idle
// - reset by soft command, or abort offline
// - reset cuts detector power two seconds
// - reset clears latched bell and bell pattern; sticky irq bits are kept
// - release energized for activation time only
// - controller-only, backup, embedded-only modes
// - release delay 0..60 s, 10 s steps
// - delayed manual release capped at 30 s
// - report manual reset required until reset
module ars_seq #(
  parameter int unsigned TICK_DIV = ars_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // field inputs
  input wire logic i_abort,
  input wire logic i_manual,
  input wire logic i_zone_a,
  input wire logic i_zone_b,
  input wire logic i_online,
  // controller output commands
  input wire logic i_ctl_bell,
  input wire logic [7:0] i_ctl_bell_sel,
  input wire logic i_ctl_release,
  // field outputs
  output logic o_bell,
  output logic [7:0] o_bell_sel,
  output logic o_release,
  output logic o_det_pwr,
  output logic o_irq,
  // axi4-lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp
);
  import ars_pkg::*;

  typedef enum logic [2:0] {
    ARS_IDLE,
    ARS_ALARM,
    ARS_DELAY,
    ARS_FIRE,
    ARS_DONE,
    ARS_DET_OFF
  } ars_state_t;

  ars_cfg_if cfg ();
  logic tick;

  ars_regs u_regs (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .o_bresp(o_bresp),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .i_araddr(i_araddr),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .cfg(cfg)
  );

  ars_tick #(.DIV(TICK_DIV)) u_tick (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .o_tick(tick)
  );

  ars_state_t st_r;
  ars_state_t st_nxt;
  logic [7:0] sec_r;
  logic [7:0] sec_nxt;
  logic man_src_r;
  logic bell_r;
  logic two_r;
  logic [7:0] abort_hold_r;
  logic abort_prev_r;

  // mode decode
  wire ars_mode_t mode = ars_mode_t'(cfg.mode);
  wire logic emb_owns = (mode == ARS_MODE_EMB_ONLY) ||
    (mode == ARS_MODE_BACKUP && (!i_online || st_r != ARS_IDLE));
  wire logic emb_on = mode != ARS_MODE_CTRL_ONLY;

  // delay selection
  wire logic [2:0] dsel = cfg.dly_sel > 3'(DLY_MAX_SEL) ? 3'(DLY_MAX_SEL) : cfg.dly_sel;
  wire logic [7:0] dly_s = 8'(dsel) * 8'(DLY_STEP_S);
  wire logic [7:0] man_dly = !cfg.man_delayed ? 8'h00 :
    (dly_s > 8'(MAN_DLY_MAX_S) ? 8'(MAN_DLY_MAX_S) : dly_s);

  // alarm decode
  wire logic det_any = o_det_pwr && (i_zone_a || i_zone_b);
  wire logic det_both = o_det_pwr && i_zone_a && i_zone_b;
  wire logic det_fire = cfg.xzone ? det_both : det_any;
  wire logic alarm_in = i_manual || det_any;

  // reset qualification: abort held through at least one tick counts only when controller offline
  wire logic abort_rst = !i_online && i_abort && abort_hold_r >= 8'(ABORT_HOLD_TICKS);
  wire logic rst_req = cfg.soft_reset || abort_rst;
  wire logic rst_ok = rst_req && st_r == ARS_DONE && !i_manual;

  // abort only holds a detector-started delay (mode 2 style restart)
  wire logic abort_hold = i_abort && !man_src_r && st_r == ARS_DELAY;

  always_comb begin
    st_nxt = st_r;
    sec_nxt = sec_r;
    case (st_r)
      ARS_IDLE: begin
        if (emb_on && i_manual) begin
          st_nxt = ARS_DELAY;
          sec_nxt = man_dly;
        end else if (emb_on && det_fire) begin
          st_nxt = ARS_DELAY;
          sec_nxt = dly_s;
        end else if (emb_on && det_any) st_nxt = ARS_ALARM;
      end
      ARS_ALARM: begin
        if (i_manual) begin
          st_nxt = ARS_DELAY;
          sec_nxt = man_dly;
        end else if (det_fire) begin
          st_nxt = ARS_DELAY;
          sec_nxt = dly_s;
        end
      end
      ARS_DELAY: begin
        if (abort_hold) sec_nxt = dly_s;
        else if (sec_r == 8'h00) begin
          st_nxt = ARS_FIRE;
          sec_nxt = cfg.act_s;
        end else if (tick) sec_nxt = sec_r - 8'h01;
      end
      ARS_FIRE: begin
        if (sec_r == 8'h00) st_nxt = ARS_DONE;
        else if (tick) sec_nxt = sec_r - 8'h01;
      end
      ARS_DONE: begin
        if (rst_ok) begin
          st_nxt = ARS_DET_OFF;
          sec_nxt = 8'(DET_OFF_S);
        end
      end
      ARS_DET_OFF: begin
        if (sec_r == 8'h00) st_nxt = ARS_IDLE;
        else if (tick) sec_nxt = sec_r - 8'h01;
      end
      default: begin
        st_nxt = ARS_IDLE;
        sec_nxt = 8'h00;
      end
    endcase
  end

  // the first tick after load may come early, so delays run up to one second short
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      st_r <= ARS_IDLE;
      sec_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      sec_r <= sec_nxt;
    end
  end

  // latched bell and its pattern
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      bell_r <= 1'b0;
      two_r <= 1'b0;
      man_src_r <= 1'b0;
    end else if (st_nxt == ARS_DET_OFF || st_nxt == ARS_IDLE && st_r == ARS_DET_OFF) begin
      bell_r <= 1'b0;
      two_r <= 1'b0;
      man_src_r <= 1'b0;
    end else if (emb_on && alarm_in && st_r != ARS_DET_OFF) begin
      bell_r <= 1'b1;
      if (i_manual || det_both) two_r <= 1'b1;
      if (i_manual && (st_r == ARS_IDLE || st_r == ARS_ALARM)) man_src_r <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      abort_hold_r <= 8'h00;
      abort_prev_r <= 1'b0;
    end else begin
      abort_prev_r <= i_abort;
      if (!i_abort) abort_hold_r <= 8'h00;
      else if (tick && abort_hold_r != 8'hFF) abort_hold_r <= abort_hold_r + 8'h01;
    end
  end

  wire logic emb_release = st_r == ARS_FIRE;
  assign o_release = emb_owns ? emb_release : i_ctl_release;
  assign o_bell = emb_owns ? bell_r : i_ctl_bell;
  assign o_bell_sel = emb_owns ? (two_r ? cfg.bell_two : cfg.bell_one) : i_ctl_bell_sel;
  assign o_det_pwr = st_r != ARS_DET_OFF;
  assign o_irq = cfg.irq;

  assign cfg.status = {2'b00, abort_prev_r, man_src_r, st_r == ARS_DONE,
    emb_owns, emb_release, bell_r};
  // one-cycle strobes into the sticky irq bits
  wire logic ev_reset = st_nxt == ARS_DET_OFF && st_r != ARS_DET_OFF;
  wire logic ev_done = st_nxt == ARS_DONE && st_r != ARS_DONE;
  wire logic ev_fire = st_nxt == ARS_FIRE && st_r != ARS_FIRE;
  wire logic ev_alarm = !bell_r && st_nxt == ARS_ALARM;
  assign cfg.events = {ev_reset, ev_done, ev_fire, ev_alarm};

  // assertions
  no_early_rst_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r != ARS_DONE || i_manual) |=> st_r != ARS_DET_OFF || $past(st_r) == ARS_DET_OFF)
    else $error("reset accepted outside done state");
  det_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_DONE && rst_ok) |=> !o_det_pwr)
    else $error("detector power not removed on reset");
  rel_end_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_FIRE && sec_r == 8'h00) |=> !emb_release)
    else $error("release outlived activation time");
  man_cap_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    man_dly <= 8'(MAN_DLY_MAX_S))
    else $error("manual delay above cap");
  dly_range_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    dly_s <= 8'(DLY_MAX_SEL * DLY_STEP_S) && (dly_s % 8'(DLY_STEP_S)) == 8'h00)
    else $error("release delay off grid");
  man_go_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_IDLE && emb_on && i_manual) |=> st_r == ARS_DELAY)
    else $error("manual alarm did not start delay");
  bell_two_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_IDLE && emb_on && i_manual && cfg.xzone) |=> ##1 two_r || !bell_r)
    else $error("manual alarm missed two-zone bell");
  ctl_only_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    mode == ARS_MODE_CTRL_ONLY && st_r == ARS_IDLE |-> o_release == i_ctl_release)
    else $error("controller-only mode overridden");
  done_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_DONE && !rst_ok) |=> cfg.status[3])
    else $error("reset-required status dropped");
  latch_clr_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_DONE && rst_ok) |=> !bell_r)
    else $error("latched bell survived reset");

  // sequence timing
  fire_go_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_DELAY && sec_r == 8'h00 && !abort_hold)
    |=> emb_release)
    else $error("release not driven after delay");
  act_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_DELAY && sec_r == 8'h00 && !abort_hold)
    |=> sec_r == $past(cfg.act_s))
    else $error("activation time not loaded");
  tick_only_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r inside {ARS_DELAY, ARS_FIRE, ARS_DET_OFF} && sec_r != 8'h00 && !tick && !abort_hold)
    |=> $stable(sec_r))
    else $error("seconds count moved without tick");
  tick_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r inside {ARS_FIRE, ARS_DET_OFF} && sec_r != 8'h00 && tick)
    |=> sec_r == $past(sec_r) - 8'h01)
    else $error("seconds count missed a tick");
  det_dly_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_ALARM && !i_manual && det_fire)
    |=> sec_r == $past(dly_s))
    else $error("detector delay not loaded");
  man_dly_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_IDLE && emb_on && i_manual)
    |=> sec_r == $past(man_dly))
    else $error("manual delay not loaded");
  done_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_FIRE && sec_r == 8'h00)
    |=> cfg.status[3])
    else $error("reset-required status not raised");
  bell_now_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_IDLE && emb_on && i_manual)
    |=> bell_r)
    else $error("bell not latched on manual alarm");

  // ownership and reset
  emb_own_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    mode == ARS_MODE_EMB_ONLY
    |-> o_release == emb_release && o_bell == bell_r)
    else $error("embedded-only outputs not owned");
  backup_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (mode == ARS_MODE_BACKUP && st_r != ARS_IDLE)
    |-> o_release == emb_release)
    else $error("backup gave up a running sequence");
  ctl_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (mode == ARS_MODE_CTRL_ONLY && st_r == ARS_IDLE)
    |=> st_r == ARS_IDLE)
    else $error("embedded logic ran in controller-only mode");
  rst_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_DONE && i_manual)
    |=> st_r == ARS_DONE)
    else $error("reset taken with manual input active");
  abort_online_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_DONE && !cfg.soft_reset && i_online)
    |=> st_r == ARS_DONE)
    else $error("abort reset taken while controller online");
  soft_rst_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_DONE && cfg.soft_reset && !i_manual)
    |=> st_r == ARS_DET_OFF && !o_det_pwr)
    else $error("soft reset not taken");
  det_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_DONE && rst_ok)
    |=> sec_r == 8'(DET_OFF_S))
    else $error("detector power-off time not loaded");
  det_back_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (st_r == ARS_DET_OFF && sec_r == 8'h00)
    |=> o_det_pwr)
    else $error("detector power not restored");
  latch_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    st_r == ARS_DET_OFF
    |-> !bell_r && !emb_release)
    else $error("latched output held during reset");
endmodule : ars_seq

//--- testbench/ars_sup_model.sv
`timescale 1ns/10ps
module ars_sup_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // bench requests
  input wire logic i_link_up,
  input wire logic i_bell,
  input wire logic [7:0] i_sel,
  input wire logic i_rel,
  input wire logic i_slow,
  // controller side outputs
  output logic o_online,
  output logic o_ctl_bell,
  output logic [7:0] o_ctl_bell_sel,
  output logic o_ctl_release
);
  logic [1:0] lag_r;
  wire logic upd = !i_slow || (lag_r == 2'h3);
  // slow controller refreshes its commands only every fourth cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      lag_r <= 2'h0;
      o_online <= 1'b1;
      o_ctl_bell <= 1'b0;
      o_ctl_bell_sel <= 8'h00;
      o_ctl_release <= 1'b0;
    end else begin
      lag_r <= i_slow ? lag_r + 2'h1 : 2'h0;
      o_online <= i_link_up;
      if (upd) begin
        o_ctl_bell <= i_bell;
        o_ctl_bell_sel <= i_sel;
        o_ctl_release <= i_rel;
      end
    end
  end
endmodule : ars_sup_model

//--- testbench/agent_release_reset_sequencer_tb.sv
`timescale 1ns/10ps
module agent_release_reset_sequencer_tb;
  import ars_pkg::*;
  localparam int TDIV = 10;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic abort = 1'b0, manual = 1'b0, zone_a = 1'b0, zone_b = 1'b0;
  logic link_up = 1'b1, bell_c = 1'b0, rel_c = 1'b0, slow = 1'b0;
  logic [7:0] sel_c = 8'h00;
  logic online, ctl_bell, ctl_rel, bell, rel, det_pwr, irq;
  logic [7:0] ctl_sel, bell_sel;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int errors = 0;
  int total_checks = 0;
  int n;
  int es;
  int mdly[3] = '{0, 1, 1};
  int dsel[3] = '{3, 1, 6};
  int exps[3] = '{0, 10, 30};

  always #10 clk = ~clk;

  ars_sup_model u_sup (.i_ref_clk(clk), .i_nrst(nrst), .i_link_up(link_up), .i_bell(bell_c),
    .i_sel(sel_c), .i_rel(rel_c), .i_slow(slow), .o_online(online), .o_ctl_bell(ctl_bell),
    .o_ctl_bell_sel(ctl_sel), .o_ctl_release(ctl_rel));

  ars_seq #(.TICK_DIV(TDIV)) u_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_abort(abort),
    .i_manual(manual), .i_zone_a(zone_a), .i_zone_b(zone_b), .i_online(online),
    .i_ctl_bell(ctl_bell), .i_ctl_bell_sel(ctl_sel), .i_ctl_release(ctl_rel), .o_bell(bell),
    .o_bell_sel(bell_sel), .o_release(rel), .o_det_pwr(det_pwr), .o_irq(irq),
    .i_awvalid(awv), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wv),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic hang(input string m);
    errors++;
    $display("CHECK FAILED t=%0t timeout %s", $time, m);
    print_verdict();
  endtask : hang

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s seen %0h exp %0h", $time, m, seen, exp);
    end
  endtask : chk

  // write address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (k == 40) hang("write");
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arv && arready) arv <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k == 40) hang("read");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axr

  // which 0 watches the release output, 1 the detector power
  task automatic wait_for(input int which, input logic lvl, input int lim, output int cyc);
    for (cyc = 0; cyc < lim; cyc++) begin
      @(posedge clk);
      if ((which == 0 ? rel : det_pwr) === lvl) break;
    end
    if (cyc == lim) hang("level");
  endtask : wait_for

  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction : inr

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    axr(OFS_CTRL, rd, rs);
    chk(rd, CTRL_RST, "ctrl reset");
    axr(OFS_TIME, rd, rs);
    chk(rd, TIME_RST, "time reset");
    axr(OFS_BELL, rd, rs);
    chk(rd, BELL_RST, "bell reset");
    axr(8'h1C, rd, rs);
    chk({30'h0, rs}, {30'h0, AXI_SLVERR}, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    axw(8'h1C, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, AXI_SLVERR}, "unmapped write");
    axw(OFS_STAT, 32'hFF, rs);
    chk({30'h0, rs}, {30'h0, AXI_OKAY}, "stat write");
    $display("test registers done");
    // backup and online: controller owns the outputs
    bell_c <= 1'b1;
    sel_c <= 8'h5A;
    rel_c <= 1'b1;
    repeat (3) @(posedge clk);
    chk({22'h0, bell, bell_sel, rel}, {22'h0, 1'b1, 8'h5A, 1'b1}, "backup pass");
    axw(OFS_CTRL, 32'h2, rs);
    repeat (3) @(posedge clk);
    chk({30'h0, bell, rel}, 32'h0, "embedded only owns");
    axw(OFS_CTRL, 32'h0, rs);
    link_up <= 1'b0;
    slow <= 1'b1;
    repeat (10) @(posedge clk);
    chk({22'h0, bell, bell_sel, rel}, {22'h0, 1'b1, 8'h5A, 1'b1}, "ctrl only");
    bell_c <= 1'b0;
    rel_c <= 1'b0;
    link_up <= 1'b1;
    slow <= 1'b0;
    axw(OFS_TIME, 32'h3, rs);
    axw(OFS_MASK, 32'h1 << EV_DONE, rs);
    $display("test modes done");
    for (int i = 0; i < 3; i++) begin
      es = exps[i];
      axw(OFS_CTRL, {25'h0, dsel[i][2:0], mdly[i][0], 1'b1, 2'h2}, rs);
      manual <= 1'b1;
      wait_for(0, 1'b1, 400, n);
      chk(inr(n, (es - 1) * TDIV, es * TDIV + 4), 32'h1, "release delay");
      chk({23'h0, bell, bell_sel}, {23'h0, 1'b1, BELL_RST[15:8]}, "two zone bell");
      wait_for(0, 1'b0, 100, n);
      chk(inr(n, 2 * TDIV, 3 * TDIV + 4), 32'h1, "activation time");
      axr(OFS_STAT, rd, rs);
      chk({31'h0, rd[3]}, 32'h1, "reset required");
      chk({31'h0, irq}, 32'h1, "done irq");
      axw(OFS_CMD, 32'h1, rs);
      repeat (5) @(posedge clk);
      chk({31'h0, det_pwr}, 32'h1, "reset refused");
      manual <= 1'b0;
      axw(OFS_CMD, 32'h1, rs);
      wait_for(1, 1'b0, 10, n);
      wait_for(1, 1'b1, 40, n);
      chk(inr(n, TDIV, 2 * TDIV + 4), 32'h1, "detector off time");
      chk({31'h0, bell}, 32'h0, "latch cleared");
      axr(OFS_STAT, rd, rs);
      // embedded-only mode keeps the owner bit set
      chk({28'h0, rd[3:0]}, 32'h4, "status cleared");
      axw(OFS_IRQ, 32'hF, rs);
      axr(OFS_IRQ, rd, rs);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      chk(rd, 32'h0, "irq bits cleared");
      $display("test release case %0d done", i);
    end
    // offline backup: abort held through one tick resets
    axw(OFS_CTRL, 32'h5, rs);
    link_up <= 1'b0;
    manual <= 1'b1;
    wait_for(0, 1'b1, 20, n);
    wait_for(0, 1'b0, 100, n);
    manual <= 1'b0;
    abort <= 1'b1;
    wait_for(1, 1'b0, 4 * TDIV, n);
    abort <= 1'b0;
    wait_for(1, 1'b1, 40, n);
    chk({31'h0, bell}, 32'h0, "abort reset clears");
    $display("test abort reset done");
    axw(OFS_CTRL, 32'h6, rs);
    zone_a <= 1'b1;
    repeat (3) @(posedge clk);
    chk({22'h0, bell, bell_sel, rel}, {22'h0, 1'b1, BELL_RST[7:0], 1'b0}, "one zone");
    $display("test one zone done");
    // second zone joins: detector delay of 20 s, two-zone pattern
    axw(OFS_CTRL, {25'h0, 3'h2, 1'b0, 1'b1, 2'h2}, rs);
    zone_b <= 1'b1;
    wait_for(0, 1'b1, 400, n);
    chk(inr(n, 19 * TDIV, 20 * TDIV + 4), 32'h1, "detector delay");
    chk({24'h0, bell_sel}, {24'h0, BELL_RST[15:8]}, "two zone detectors");
    $display("test two zone done");
    print_verdict();
  end
endmodule : agent_release_reset_sequencer_tb
